// [rtl/ts_defines.svh]
// Register offsets, field limits and timing counts of the periodic time switch.
`ifndef TS_DEFINES_SVH
`define TS_DEFINES_SVH

// ============================================================
// Register byte offsets
`define TS_OFS_CTRL      8'h00
`define TS_OFS_START_DAY 8'h04
`define TS_OFS_START_TOD 8'h08
`define TS_OFS_DURATION  8'h0c
`define TS_OFS_PERIOD    8'h10
`define TS_OFS_NOW_DAY   8'h14
`define TS_OFS_NOW_TOD   8'h18
`define TS_OFS_STATUS    8'h1c
`define TS_OFS_NEXT_DAY  8'h20
`define TS_OFS_NEXT_TOD  8'h24
`define TS_OFS_NOW_SEC   8'h28

// ============================================================
// Field limits and reset values
`define TS_DAY_MAX       16'h8eac
`define TS_TOD_MAX       17'h1517f
`define TS_SPAN_MIN      24'h000003
`define TS_SPAN_MAX      24'h83d600
`define TS_SEC_PER_DAY   32'h00015180
`define TS_RST_SPAN      24'h000003

// ============================================================
// Time base: one second expressed in ns over the 4 ns clock period
`define TS_SEC_NS        1000000000
`define TS_CLK_NS        4
`define TS_CYC_PER_SEC   (`TS_SEC_NS / `TS_CLK_NS)

`endif

// [rtl/ts_pkg.sv]
// Types shared by the periodic time switch.
package ts_pkg;

	// ============================================================
	// Complete state of the time switch
	typedef struct packed {
		logic        en;
		logic [15:0] start_day;
		logic [16:0] start_tod;
		logic [23:0] dur;
		logic [23:0] per;
		logic [15:0] now_day_hold;
		logic [31:0] now;
		logic [27:0] div;
		logic        reload;
		logic        started;
		logic [31:0] cyc_start;
		logic [31:0] next_start;
		logic        cv_busy;
		logic [31:0] cv_rem;
		logic [15:0] cv_day;
		logic [15:0] nx_day;
		logic [16:0] nx_tod;
		logic        sig;
		logic        ph_valid;
		logic        ph_write;
		logic [7:0]  ph_addr;
		logic [31:0] hrdata;
		logic        hreadyout;
		logic        hresp;
	} ts_state_t;

endpackage : ts_pkg

// [rtl/ts_time_switch.sv]
// Calendar-driven periodic time switch with an AHB-Lite register slave.
//
// Notes on behaviour
// - One binary output whose level depends only on elapsed time and schedule.
// - Output is one while the switch is on, zero while off.
// - Enable bit turns the function on or off; reset leaves it off.
// - First cycle starts at programmed date 2000..2099 plus time of day.
// - High for duration from each cycle start; period repeats; both 3 s..2400 h.
// - Present output level is readable as status.
// - Date and time of the next high interval are readable.
//
// Local design decisions: the register offsets and the AHB-Lite slave port.
`timescale 1ns/10ps
`include "ts_defines.svh"

module ts_time_switch
	import ts_pkg::*;
#(
	parameter logic [27:0] CYC_PER_SEC = 28'(`TS_CYC_PER_SEC)
)
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	output logic             ts_level
);

	ts_state_t   st_reg;
	ts_state_t   st_next;
	logic [31:0] start_abs;
	logic [31:0] elapsed;
	logic [23:0] span_w;
	logic        tick;
	logic        due;

	// ============================================================
	// Derived values
	// Start instant as seconds since the first day of 2000, day number zero.
	assign start_abs = 32'({16'h0000, st_reg.start_day} * `TS_SEC_PER_DAY)
		+ {15'h0000, st_reg.start_tod};
	assign elapsed   = st_reg.now - st_reg.cyc_start;
	assign tick      = (st_reg.div == CYC_PER_SEC - 28'h0000001);
	assign due       = st_reg.en && !st_reg.reload
		&& (st_reg.now >= st_reg.next_start);

	// Span writes are clamped into the legal range of 3 s to 2400 h.
	always_comb
	begin
		if (hwdata[23:0] < `TS_SPAN_MIN || hwdata[31:24] != 8'h00)
			span_w = (hwdata[31:24] != 8'h00) ? `TS_SPAN_MAX : `TS_SPAN_MIN;
		else if (hwdata[23:0] > `TS_SPAN_MAX)
			span_w = `TS_SPAN_MAX;
		else
			span_w = hwdata[23:0];
	end

	// ============================================================
	// Next-state logic
	// One process computes the whole state so no field has two drivers.
	always_comb
	begin
		st_next           = st_reg;
		st_next.hreadyout = 1'b1;
		st_next.hresp     = 1'b0;
		st_next.reload    = 1'b0;

		// Local second counter acting as the real-time calendar.
		if (tick)
		begin
			st_next.div = 28'h0000000;
			st_next.now = st_reg.now + 32'h00000001;
		end
		else
			st_next.div = st_reg.div + 28'h0000001;

		// Register write in the data phase; any schedule change restarts.
		if (st_reg.ph_valid && st_reg.ph_write)
		begin
			unique case (st_reg.ph_addr)
				`TS_OFS_CTRL:
				begin
					st_next.en     = hwdata[0];
					st_next.reload = 1'b1;
				end
				`TS_OFS_START_DAY:
				begin
					st_next.start_day = (hwdata[15:0] > `TS_DAY_MAX)
						? `TS_DAY_MAX : hwdata[15:0];
					st_next.reload    = 1'b1;
				end
				`TS_OFS_START_TOD:
				begin
					st_next.start_tod = (hwdata[16:0] > `TS_TOD_MAX)
						? `TS_TOD_MAX : hwdata[16:0];
					st_next.reload    = 1'b1;
				end
				`TS_OFS_DURATION:
				begin
					st_next.dur    = span_w;
					st_next.reload = 1'b1;
				end
				`TS_OFS_PERIOD:
				begin
					st_next.per    = span_w;
					st_next.reload = 1'b1;
				end
				`TS_OFS_NOW_DAY:
					st_next.now_day_hold = hwdata[15:0];
				`TS_OFS_NOW_TOD:
				begin
					// Setting the clock commits the held day as well.
					st_next.now = 32'({16'h0000, st_reg.now_day_hold}
						* `TS_SEC_PER_DAY) + {15'h0000, hwdata[16:0]};
					st_next.div    = 28'h0000000;
					st_next.reload = 1'b1;
				end
				default:
					st_next.reload = 1'b0;
			endcase
		end

		// Schedule: restart at the start instant, then step one period
		// per clock until caught up, so a past start date is honoured.
		if (!st_reg.en || st_reg.reload)
		begin
			st_next.started    = 1'b0;
			st_next.next_start = start_abs;
		end
		else if (due)
		begin
			st_next.started    = 1'b1;
			st_next.cyc_start  = st_reg.next_start;
			st_next.next_start = st_reg.next_start
				+ {8'h00, st_reg.per};
		end

		// Output level is a registered function of enable, elapsed time and the schedule.
		// A duration not below the period bridges every period step, so
		// only a real low interval sees the one-clock restart gap.
		st_next.sig = st_reg.en && st_reg.started
			&& ((st_reg.dur >= st_reg.per)
			|| (!due && (elapsed < {8'h00, st_reg.dur})));

		// Convert the next start into day number and time of day by
		// repeated subtraction; a change of the target restarts it.
		if (st_next.next_start != st_reg.next_start || st_reg.reload)
		begin
			st_next.cv_busy = 1'b1;
			st_next.cv_rem  = st_next.next_start;
			st_next.cv_day  = 16'h0000;
		end
		else if (st_reg.cv_busy)
		begin
			if (st_reg.cv_rem >= `TS_SEC_PER_DAY)
			begin
				st_next.cv_rem = st_reg.cv_rem - `TS_SEC_PER_DAY;
				st_next.cv_day = st_reg.cv_day + 16'h0001;
			end
			else
			begin
				st_next.cv_busy = 1'b0;
				st_next.nx_day  = st_reg.cv_day;
				st_next.nx_tod  = st_reg.cv_rem[16:0];
			end
		end

		// AHB-Lite address phase: capture and prepare read data.
		st_next.ph_valid = hsel && hready && htrans[1];
		st_next.ph_write = hwrite;
		st_next.ph_addr  = haddr[7:0];
		if (hsel && hready && htrans[1] && !hwrite && haddr[31:8] == 24'h0)
		begin
			unique case (haddr[7:0])
				`TS_OFS_CTRL:      st_next.hrdata = {31'h0, st_reg.en};
				`TS_OFS_START_DAY: st_next.hrdata = {16'h0, st_reg.start_day};
				`TS_OFS_START_TOD: st_next.hrdata = {15'h0, st_reg.start_tod};
				`TS_OFS_DURATION:  st_next.hrdata = {8'h0, st_reg.dur};
				`TS_OFS_PERIOD:    st_next.hrdata = {8'h0, st_reg.per};
				`TS_OFS_NOW_DAY:   st_next.hrdata = {16'h0, st_reg.now_day_hold};
				`TS_OFS_NOW_SEC:   st_next.hrdata = st_reg.now;
				`TS_OFS_STATUS:
					st_next.hrdata = {29'h0, st_reg.cv_busy,
						st_reg.started, st_reg.sig};
				`TS_OFS_NEXT_DAY:  st_next.hrdata = {16'h0, st_reg.nx_day};
				`TS_OFS_NEXT_TOD:  st_next.hrdata = {15'h0, st_reg.nx_tod};
				default:           st_next.hrdata = 32'h00000000;
			endcase
		end
		else if (hsel && hready && htrans[1])
			st_next.hrdata = 32'h00000000;

		// Upper address bits must be zero for a write to land.
		if (haddr[31:8] != 24'h0)
			st_next.ph_addr = 8'hff;
	end

	// ============================================================
	// State register
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			st_reg           <= '0;
			st_reg.dur       <= `TS_RST_SPAN;
			st_reg.per       <= `TS_RST_SPAN;
			st_reg.hreadyout <= 1'b1;
		end
		else
			st_reg <= st_next;
	end

	assign hrdata    = st_reg.hrdata;
	assign hreadyout = st_reg.hreadyout;
	assign hresp     = st_reg.hresp;
	assign ts_level  = st_reg.sig;

endmodule : ts_time_switch

// [bench/ts_time_switch_properties.sv]
// Concurrent checks on the ports of the time switch.
`timescale 1ns/10ps
module ts_checker
	import ts_pkg::*;
#(parameter logic [27:0] CYC_PER_SEC = 28'h000000a)
(
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic        ts_level
);
	logic       dv, dw, en;
	logic [7:0] da;
	logic [2:0] off_cnt;
	logic [31:0] dm, pm;
	// ============================================================
	// Follow data phases; count cycles since the enable went low.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			dv      <= 1'b0;
			dw      <= 1'b0;
			da      <= 8'h00;
			en      <= 1'b0;
			off_cnt <= 3'h7;
			dm      <= 32'h00000000;
			pm      <= 32'h00000000;
		end
		else
		begin
			dv <= hsel && hready && htrans[1];
			dw <= hwrite;
			da <= haddr[7:0];
			if (dv && dw && da == 8'h00)
				en <= hwdata[0];
			// Raw words suffice: clamping keeps their order.
			if (dv && dw && da == 8'h0c)
				dm <= hwdata;
			if (dv && dw && da == 8'h10)
				pm <= hwdata;
			off_cnt <= en ? 3'h0 : off_cnt + {2'h0, off_cnt != 3'h7};
		end
	end
	// ============================================================
	// Properties; the level may lag a disable by two clocks.
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence s_rd;
		dv && !dw;
	endsequence
	a_ready_high: assert property (hreadyout)
		else $error("hreadyout low");
	a_resp_okay: assert property (!hresp)
		else $error("hresp not okay");
	a_off_low: assert property (off_cnt > 3'h2 |-> !ts_level)
		else $error("level high while disabled");
	a_high_hold: assert property ($rose(ts_level) |-> ts_level[*8])
		else $error("high pulse too short");
	a_cont_high: assert property ($fell(ts_level) |->
		dm < pm || !en || $past(dv && dw, 2))
		else $error("level fell with duration not below period");
	a_status_bits: assert property (s_rd ##0 da == 8'h1c |->
		hrdata[31:3] == 29'h0 &&
		(hrdata[0] == ts_level || hrdata[0] == $past(ts_level)))
		else $error("status word wrong");
	a_unmapped_zero: assert property (s_rd ##0 da > 8'h28 |-> !hrdata)
		else $error("unmapped read not zero");
	a_next_tod: assert property (s_rd ##0 da == 8'h24 |->
		hrdata < 32'h00015180) else $error("next time out of day");
	a_span_range: assert property (s_rd ##0 (da == 8'h0c || da == 8'h10) |->
		hrdata >= 32'h3 && hrdata <= 32'h83d600)
		else $error("span out of range");
endmodule : ts_checker

bind ts_time_switch ts_checker #(.CYC_PER_SEC(CYC_PER_SEC)) u_chk (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
	.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
	.ts_level(ts_level));

// [bench/ts_time_switch_tb.sv]
// Self-checking bench for the periodic time switch.
`timescale 1ns/10ps
module ts_time_switch_tb
	import ts_pkg::*;
;
	logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, rd_dp = 0;
	logic [31:0] haddr = 0, hwdata = 0, v, hrdata, exp_q[$], msk_q[$];
	logic [1:0]  htrans = 0;
	logic        hreadyout, hresp, ts_level;
	int          bad_count = 0, comparisons = 0, seed = 32'h669d;
	int          cyc = 0, t0;
	logic [31:0] ta[4] = '{32'h0c, 32'h10, 32'h04, 32'h08};
	logic [31:0] tw[4] = '{32'h0, 32'hffffff, 32'hffff, 32'h1ffff};
	logic [31:0] te[4] = '{32'h3, 32'h83d600, 32'h8eac, 32'h1517f};
	// Ten clocks per second keeps every schedule short.
	ts_time_switch #(.CYC_PER_SEC(28'd10)) DUT (.hclk(hclk),
		.hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.ts_level(ts_level));
	// ============================================================
	// Clock, cycle count and read-data monitor.
	always #2 hclk = ~hclk;
	always @(posedge hclk) cyc <= cyc + 1;
	always @(posedge hclk)
		if (rd_dp && hreadyout === 1'b1)
			check("hrdata", hrdata & msk_q.pop_front(), exp_q.pop_front());
	always @(posedge hclk)
		if (rd_dp && hreadyout === 1'b1)
			check("hresp", {31'h0, hresp}, 32'h0);
	task automatic check(string nm, logic [31:0] s, logic [31:0] e);
		comparisons++;
		if (s !== e)
		begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask : check
	// Address phase held until hready is seen high.
	task automatic addr_ph(logic [31:0] a, logic w);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
	endtask : addr_ph
	task automatic wr(logic [31:0] a, logic [31:0] d);
		addr_ph(a, 1'b1);
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
	endtask : wr
	task automatic rd(logic [31:0] a, logic [31:0] m, logic [31:0] e);
		exp_q.push_back(e & m);
		msk_q.push_back(m);
		addr_ph(a, 1'b0);
		rd_dp <= 1'b1;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd_dp <= 1'b0;
	endtask : rd
	// The level is looked at mid-cycle, where it has settled.
	task automatic lvl(logic e);
		@(negedge hclk);
		check("ts_level", {31'h0, ts_level}, {31'h0, e});
		rd(32'h1c, 32'h1, {31'h0, e});
	endtask : lvl
	task automatic upto(int k);
		while (cyc - t0 < k) @(posedge hclk);
	endtask : upto
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : wrap_up
	// ============================================================
	// Main sequence.
	initial
	begin
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		rd(32'h00, '1, 0);
		rd(32'h0c, '1, 3);
		lvl(1'b0);
		rd(32'h2c, '1, 0);
		$display("test reset done");
		for (int i = 0; i < 4; i++)
		begin
			wr(ta[i], tw[i]);
			rd(ta[i], '1, te[i]);
		end
		repeat (4)
		begin
			v = 32'd3 + {$random(seed)} % 32'd8639998;
			wr(32'h10, v);
			rd(32'h10, '1, v);
		end
		$display("test limits done");
		// Start at second 3, high 3 s of every 6 s.
		wr(32'h04, 0);
		wr(32'h08, 3);
		wr(32'h0c, 3);
		wr(32'h10, 6);
		wr(32'h00, 1);
		wr(32'h14, 0);
		wr(32'h18, 0);
		t0 = cyc;
		upto(15);
		lvl(1'b0);
		rd(32'h20, '1, 0);
		rd(32'h24, '1, 3);
		rd(32'h28, '1, 2);
		upto(47);
		lvl(1'b1);
		upto(70);
		rd(32'h24, '1, 9);
		upto(77);
		lvl(1'b0);
		upto(107);
		lvl(1'b1);
		$display("test schedule done");
		// Disable, then duration above period stays high.
		wr(32'h00, 0);
		repeat (4) @(posedge hclk);
		lvl(1'b0);
		wr(32'h0c, 6);
		wr(32'h10, 3);
		wr(32'h08, 0);
		wr(32'h18, 0);
		wr(32'h00, 1);
		t0 = cyc;
		for (int k = 1; k < 5; k++)
		begin
			upto(30 * k);
			lvl(1'b1);
		end
		$display("test continuous done");
		wrap_up();
	end
	// Watchdog well beyond the few hundred cycles the tests need.
	initial
	begin
		#(4 * 5000);
		bad_count++;
		wrap_up();
	end
endmodule : ts_time_switch_tb
